// *** dv/soft_power_wake_and_smi_enable_bench.sv ***
`default_nettype none
module soft_power_wake_and_smi_enable_bench
  import spwake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, psel, penable, pwrite, err, ce;
  logic        al, al2, g1, g2, btn, pready, pslverr;
  logic        pon_n, off_req, pg, smi_o, smi_oe, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  smi;
  wire  [6:0]  pins;
  int          bad_count, checked, cyc, offs, n0;
  logic [16:0] rows[10] = '{17'h0B180,
    17'h0B200, 17'h0B300, 17'h0B400, 17'h1B1FF,
    17'h0B1D3, 17'h1B4A5, 17'h0B4A5,
    17'h1B5FF, 17'h0B580};
  logic [15:0] ev[7] = '{16'hB201, 16'hB202, 16'hB204, 16'hB208,
    16'hB240, 16'hB301, 16'hB302};
  ////////////////////////////////////////////////////////////////
  spwake_top spwake_top_inst (.CLK(clk), .RESET_N(reset_n), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RING_ONE(pins[0]), .RING_TWO(pins[1]), .KBD_CLK(pins[2]),
    .MOUSE_CLK(pins[3]), .IR_RX_TWO(pins[4]), .UART1_RX(pins[5]),
    .UART2_RX(pins[6]), .RTC_ALARM(al), .RTC_ALARM_TWO(al2),
    .GROUP_INT_ONE(g1), .GROUP_INT_TWO(g2), .POWER_BUTTON(btn),
    .SMI_SOURCES(smi), .POWER_ON_OUT_N(pon_n), .POWER_OFF_REQ(off_req),
    .POWER_GOOD_SEL(pg), .SYS_MGMT_INT_N_O(smi_o),
    .SYS_MGMT_INT_N_OE(smi_oe), .IRQ(irq));
  spwake_pins spwake_pins_inst (.clk(clk), .pins(pins));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (off_req === 1'b1) offs <= offs + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task cb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, psel, penable, pwrite, al, al2, g1, g2, btn} = '0;
    {paddr, pwdata, smi, cyc, offs} = '0;
    ce = 1'b1;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    cb(pon_n, 1'b1);
    for (int i = 0; i < 10; i++) begin
      apb(rows[i][16], rows[i][15:8], rows[i][7:0]);
      if (!rows[i][16]) chk(rd, {24'h0, rows[i][7:0]});
    end
    cb(pg, 1'b1);
    apb(1'b1, 8'hB1, 8'h93);
    @(posedge clk);
    cb(pg, 1'b0);
    apb(1'b1, 8'hB0, 8'hFF);
    apb(1'b1, 8'hC0, 8'h03);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      spwake_pins_inst.fall(i);
      repeat (4) @(posedge clk);
      cb(pon_n, 1'b0);
      cb(irq, 1'b1);
      rc(8'hC1, 8'h01);
      rc(ev[i][15:8], ev[i][7:0]);
      rc(ev[i][15:8], 8'h00);
      cb(pon_n, 1'b1);
    end
    al <= 1'b1;
    repeat (3) @(posedge clk);
    rc(8'hB2, 8'h80);
    rc(8'hB2, 8'h00);
    al2 <= 1'b1;
    g1 <= 1'b1;
    repeat (3) @(posedge clk);
    rc(8'hB3, 8'h10);
    rc(8'hB2, 8'h10);
    rc(8'hB2, 8'h10);
    {g1, g2} <= 2'b01;
    repeat (3) @(posedge clk);
    rc(8'hB2, 8'h20);
    g2 <= 1'b0;
    repeat (3) @(posedge clk);
    rc(8'hB2, 8'h00);
    rc(8'hC1, 8'h01);
    $display("test events done");
    n0 = offs;
    for (int k = 0; k < 2; k++) begin
      btn <= 1'b1;
      repeat (3) @(posedge clk);
      btn <= 1'b0;
      cb(pon_n, 1'b1);
      chk(offs, n0 + 1);
      rc(8'hB3, 8'h04);
      apb(1'b1, 8'hB1, 8'h13);
    end
    rc(8'hC1, 8'h02);
    apb(1'b1, 8'hB0, 8'h00);
    spwake_pins_inst.fall(0);
    repeat (4) @(posedge clk);
    cb(pon_n, 1'b1);
    cb(irq, 1'b0);
    apb(1'b0, 8'h10, 8'h00);
    cb(err, 1'b1);
    chk(rd, 32'h0);
    $display("test button done");
    apb(1'b1, 8'hB5, 8'h80);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'hB4, 8'h01 << i);
      smi <= 8'h01 << i;
      repeat (3) @(posedge clk);
      cb(smi_o, 1'b0);
      cb(smi_oe, 1'b0);
      smi <= ~(8'h01 << i);
      repeat (3) @(posedge clk);
      cb(smi_o, 1'b1);
    end
    apb(1'b1, 8'hB5, 8'h00);
    apb(1'b1, 8'hB4, 8'hFF);
    repeat (3) @(posedge clk);
    cb(smi_oe, 1'b1);
    $display("test smi done");
    ce <= 1'b0;
    spwake_pins_inst.fall(1);
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    rc(8'hB2, 8'h01);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rc(8'hB1, 8'h80);
    cb(smi_oe, 1'b1);
    $display("test freeze and reset done");
    finish_test;
  end
endmodule // soft_power_wake_and_smi_enable_bench
`default_nettype wire

// *** dv/spwake_pins.sv ***
`default_nettype none
module spwake_pins (
  input  wire logic       clk,
  output logic      [6:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  // Wake pins idle high
  initial pins = 7'h7F;
  // One falling edge, low for two cycles, then high again
  task automatic fall(input int i);
    @(posedge clk);
    pins[i] <= 1'b0;
    repeat (2) @(posedge clk);
    pins[i] <= 1'b1;
  endtask
endmodule // spwake_pins
`default_nettype wire

// *** rtl/spwake_pkg.sv ***
`default_nettype none
package spwake_pkg;
  typedef enum logic [1:0] {
    SPW_IDLE   = 2'b01,
    SPW_ACCESS = 2'b10
  } spwake_apb_t;
endpackage
`default_nettype wire

// *** rtl/spwake_regs.svh ***
// Operation
// R1 - Wake enable two bit 0 enables UART 1 receive wake and bit 1 enables UART 2 receive wake.
// R2 - Wake enable two bit 4 enables the second alarm as a wake source and resets to 0.
// R3 - Wake enable two bit 6 selects the power-on pin as a power-good input and resets to 0.
// R4 - Wake enable two bit 7 resets to 1 and lets the power button switch power off.
// R5 - Each wake status bit reads 1 when its event occurred and 0 when not since last cleared.
// R6 - Status one latches falling edges of ring 1, ring 2, kbd clock, mouse clock, IR rx 2.
// R7 - Status one bit 7 captures the alarm signal and clears on read.
// R8 - Status one bits 4 and 5 mirror group interrupts 1 and 2 unlatched.
// R9 - Latched events stay held for power control until software reads the flag.
// R10 - Status two bits 0 and 1 latch falling edges on UART receive pins, clear on read.
// R11 - Status two bit 4 reports second alarm status and clears on read.
// R12 - Status two bit 2 latches a button press, clears on read, and does not drive power.
// R13 - SMI enable one gates eight interrupt sources onto the group SMI.
// R14 - An enabled wake event turns system power on through the power-on output.
// R15 - Group SMI reaches its pin only when the route enable bit is set, else the pin floats.
// R16 - Reserved bits read as zero and ignore writes.
`ifndef SPWAKE_REGS_SVH
`define SPWAKE_REGS_SVH
`define SPW_ADDR_W        12
`define SPW_IDX_STAT_ONE  8'hB2
`define SPW_IDX_STAT_TWO  8'hB3
`define SPW_IDX_SMI_EN    8'hB4
`define SPW_IDX_WAKE_EN2  8'hB1
`define SPW_IDX_WAKE_EN1  8'hB0
`define SPW_IDX_SMI_ROUTE 8'hB5
`define SPW_IDX_IRQ_MASK  8'hC0
`define SPW_IDX_IRQ_STAT  8'hC1
`define SPW_EN2_RST       8'h80
`define SPW_EN2_MASK      8'hD3
`define SPW_STAT2_MASK    8'h17
`define SPW_ROUTE_MASK    8'h80
`define SPW_IRQ_MASK_W    8'h03
`define SPW_ZERO8         8'h00
`define SPW_STAT1_MASK    8'hCF
`define SPW_WAKE2_MASK    8'h13
`define SPW_PINS_IDLE     7'h7F
`define SPW_B_ROUTE       7
`define SPW_B_UART1_RX_EVENT        0
`define SPW_B_UART2_RX_EVENT        1
`define SPW_B_BUTTON      2
`define SPW_B_AL2         4
`define SPW_B_PG          6
`define SPW_B_OFF         7
`define SPW_B_GP1         4
`define SPW_B_GP2         5
`define SPW_B_ALARM       7
`endif

// *** rtl/spwake_top.sv ***
// The implementer's own choice: register access over APB.
`include "spwake_regs.svh"
`default_nettype none
module spwake_top
  import spwake_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RING_ONE,
  input  wire logic        RING_TWO,
  input  wire logic        KBD_CLK,
  input  wire logic        MOUSE_CLK,
  input  wire logic        IR_RX_TWO,
  input  wire logic        UART1_RX,
  input  wire logic        UART2_RX,
  input  wire logic        RTC_ALARM,
  input  wire logic        RTC_ALARM_TWO,
  input  wire logic        GROUP_INT_ONE,
  input  wire logic        GROUP_INT_TWO,
  input  wire logic        POWER_BUTTON,
  input  wire logic [7:0]  SMI_SOURCES,
  output logic             POWER_ON_OUT_N,
  output logic             POWER_OFF_REQ,
  output logic             POWER_GOOD_SEL,
  output logic             SYS_MGMT_INT_N_O,
  output logic             SYS_MGMT_INT_N_OE,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  spwake_apb_t state_q;
  logic [7:0]  index;
  logic        setup;
  logic        access;
  logic        mapped;
  logic        rd_one;
  logic        rd_two;
  logic        rd_irq;

  function automatic logic [7:0] spw_word(input logic [11:0] a);
    spw_word = a[9:2];
  endfunction

  assign index  = spw_word(PADDR);
  assign setup  = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && (state_q == SPW_ACCESS);
  assign mapped = (index == `SPW_IDX_STAT_ONE) || (index == `SPW_IDX_STAT_TWO) ||
                  (index == `SPW_IDX_SMI_EN) || (index == `SPW_IDX_WAKE_EN2) ||
                  (index == `SPW_IDX_WAKE_EN1) || (index == `SPW_IDX_SMI_ROUTE) ||
                  (index == `SPW_IDX_IRQ_MASK) || (index == `SPW_IDX_IRQ_STAT);
  assign rd_one = access && !PWRITE && (index == `SPW_IDX_STAT_ONE);
  assign rd_two = access && !PWRITE && (index == `SPW_IDX_STAT_TWO);
  assign rd_irq = access && !PWRITE && (index == `SPW_IDX_IRQ_STAT);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_q <= SPW_IDLE;
    end else if (CE) begin
      unique case (state_q)
        SPW_IDLE:   state_q <= setup ? SPW_ACCESS : SPW_IDLE;
        SPW_ACCESS: state_q <= SPW_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0] wake_enable_one_q;
  logic [7:0] wake_enable_two_q;
  logic [7:0] smi_source_enable_one_q;
  logic [7:0] smi_route_q;
  logic [7:0] irq_mask_q;
  logic       wr;

  assign wr = access && PWRITE;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wake_enable_one_q       <= `SPW_ZERO8;
      wake_enable_two_q       <= `SPW_EN2_RST; // R2 R3 R4
      smi_source_enable_one_q <= `SPW_ZERO8;
      smi_route_q             <= `SPW_ZERO8;
      irq_mask_q              <= `SPW_ZERO8;
    end else if (CE && wr) begin
      if (index == `SPW_IDX_WAKE_EN1) begin
        wake_enable_one_q <= PWDATA[7:0];
      end
      if (index == `SPW_IDX_WAKE_EN2) begin
        wake_enable_two_q <= PWDATA[7:0] & `SPW_EN2_MASK; // R1 R16
      end
      if (index == `SPW_IDX_SMI_EN) begin
        smi_source_enable_one_q <= PWDATA[7:0]; // R13
      end
      if (index == `SPW_IDX_SMI_ROUTE) begin
        smi_route_q <= PWDATA[7:0] & `SPW_ROUTE_MASK; // R16
      end
      if (index == `SPW_IDX_IRQ_MASK) begin
        irq_mask_q <= PWDATA[7:0] & `SPW_IRQ_MASK_W;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and sticky status
  logic [6:0] pins_q;
  logic [6:0] pins_now;
  logic [6:0] fall;
  logic       alarm_q;
  logic       alarm2_q;
  logic       button_q;
  logic [7:0] stat_one_q;
  logic [7:0] stat_two_q;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] stat_one_view;

  assign pins_now = {UART2_RX, UART1_RX, IR_RX_TWO, MOUSE_CLK, KBD_CLK, RING_TWO, RING_ONE};
  assign fall     = pins_q & ~pins_now;
  assign set_one  = {RTC_ALARM && !alarm_q, fall[4], 2'b00, fall[3:0]}; // R6 R7
  assign set_two  = {3'b000, RTC_ALARM_TWO && !alarm2_q, 1'b0,
                     POWER_BUTTON && !button_q, fall[6], fall[5]}; // R10 R11 R12
  assign stat_one_view = {stat_one_q[`SPW_B_ALARM], stat_one_q[6],
                          GROUP_INT_TWO, GROUP_INT_ONE, stat_one_q[3:0]}; // R8

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pins_q   <= `SPW_PINS_IDLE;
      alarm_q  <= 1'b0;
      alarm2_q <= 1'b0;
      button_q <= 1'b0;
    end else if (CE) begin
      pins_q   <= pins_now;
      alarm_q  <= RTC_ALARM;
      alarm2_q <= RTC_ALARM_TWO;
      button_q <= POWER_BUTTON;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      stat_one_q <= `SPW_ZERO8;
      stat_two_q <= `SPW_ZERO8;
    end else if (CE) begin
      // Clear only what the read reported
      stat_one_q <= ((rd_one ? stat_one_q & ~PRDATA[7:0] : stat_one_q) | set_one)
                    & `SPW_STAT1_MASK; // R5 R9
      stat_two_q <= ((rd_two ? stat_two_q & ~PRDATA[7:0] : stat_two_q) | set_two)
                    & `SPW_STAT2_MASK; // R5 R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power, SMI and interrupt outputs
  logic [7:0] wake_hit_one;
  logic [7:0] wake_hit_two;
  logic       wake_any;
  logic       group_smi;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_ev;

  assign wake_hit_one = stat_one_view & wake_enable_one_q;
  assign wake_hit_two = stat_two_q & wake_enable_two_q & `SPW_WAKE2_MASK; // R12
  assign wake_any     = |wake_hit_one || |wake_hit_two; // R14
  assign group_smi    = |(SMI_SOURCES & smi_source_enable_one_q); // R13
  assign irq_ev       = {POWER_BUTTON && !button_q, wake_any};

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      POWER_ON_OUT_N    <= 1'b1;
      POWER_OFF_REQ     <= 1'b0;
      POWER_GOOD_SEL    <= 1'b0;
      SYS_MGMT_INT_N_O  <= 1'b1;
      SYS_MGMT_INT_N_OE <= 1'b1;
      irq_stat_q        <= 2'b00;
      IRQ               <= 1'b0;
    end else if (CE) begin
      POWER_ON_OUT_N    <= !wake_any; // R14
      POWER_OFF_REQ     <= POWER_BUTTON && !button_q && wake_enable_two_q[`SPW_B_OFF]; // R4
      POWER_GOOD_SEL    <= wake_enable_two_q[`SPW_B_PG]; // R3
      SYS_MGMT_INT_N_O  <= !group_smi;
      SYS_MGMT_INT_N_OE <= !(smi_route_q[`SPW_B_ROUTE] && group_smi); // R15
      irq_stat_q        <= (rd_irq ? irq_stat_q & ~PRDATA[1:0] : irq_stat_q) | irq_ev;
      IRQ               <= |(irq_stat_q & irq_mask_q[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  logic [7:0] rdata;

  always_comb begin
    rdata = `SPW_ZERO8;
    unique case (index)
      `SPW_IDX_WAKE_EN1:  rdata = wake_enable_one_q;
      `SPW_IDX_WAKE_EN2:  rdata = wake_enable_two_q;
      `SPW_IDX_STAT_ONE:  rdata = stat_one_view;
      `SPW_IDX_STAT_TWO:  rdata = stat_two_q;
      `SPW_IDX_SMI_EN:    rdata = smi_source_enable_one_q;
      `SPW_IDX_SMI_ROUTE: rdata = smi_route_q;
      `SPW_IDX_IRQ_MASK:  rdata = irq_mask_q;
      `SPW_IDX_IRQ_STAT:  rdata = {6'h00, irq_stat_q};
      default:            rdata = `SPW_ZERO8;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY  <= setup;
      PSLVERR <= setup && !mapped;
      PRDATA  <= (setup && !PWRITE) ? {24'h000000, rdata} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_EN2_RESET: assert property (@(posedge CLK) // R4
      $rose(RESET_N) |-> wake_enable_two_q == `SPW_EN2_RST)
    else $error("wake enable two reset wrong");

  AST_EN2_WRITE: assert property (@(posedge CLK) disable iff (!RESET_N) // R1
      CE && wr && index == `SPW_IDX_WAKE_EN2 |=>
      wake_enable_two_q == ($past(PWDATA[7:0]) & `SPW_EN2_MASK))
    else $error("wake enable two write lost");

  AST_UART1_RX_EVENT_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N) // R10
      CE && fall[5] |=> stat_two_q[`SPW_B_UART1_RX_EVENT])
    else $error("uart1_rx_event edge lost");

  AST_UART2_RX_EVENT_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N) // R10
      CE && fall[6] |=> stat_two_q[`SPW_B_UART2_RX_EVENT])
    else $error("uart2_rx_event edge lost");

  AST_RING1_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N) // R6
      CE && fall[0] |=> stat_one_q[0])
    else $error("ring one edge lost");

  AST_IR_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N) // R6
      CE && fall[4] |=> stat_one_q[6])
    else $error("infrared edge lost");

  AST_ALARM_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N) // R7
      CE && RTC_ALARM && !alarm_q |=> stat_one_q[`SPW_B_ALARM])
    else $error("alarm lost");

  AST_ALARM2_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N) // R11
      CE && RTC_ALARM_TWO && !alarm2_q |=> stat_two_q[`SPW_B_AL2])
    else $error("alarm two lost");

  AST_BUTTON_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N) // R12
      CE && POWER_BUTTON && !button_q |=> stat_two_q[`SPW_B_BUTTON])
    else $error("button press lost");

  AST_BUTTON_NO_WAKE: assert property (@(posedge CLK) disable iff (!RESET_N) // R12
      stat_one_view == `SPW_ZERO8 && (stat_two_q & `SPW_WAKE2_MASK) == `SPW_ZERO8
      |-> !wake_any)
    else $error("button drives power");

  AST_STAT_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N) // R9
      CE && stat_one_q[0] && !rd_one |=> stat_one_q[0])
    else $error("ring one dropped");

  AST_STAT2_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N) // R9
      CE && stat_two_q[`SPW_B_UART1_RX_EVENT] && !rd_two |=> stat_two_q[`SPW_B_UART1_RX_EVENT])
    else $error("uart1_rx_event status dropped");

  AST_READ_CLR: assert property (@(posedge CLK) disable iff (!RESET_N) // R5
      CE && rd_two && set_two == `SPW_ZERO8 |=>
      (stat_two_q & $past(PRDATA[7:0])) == `SPW_ZERO8)
    else $error("no clear");

  AST_GROUP_MIRROR: assert property (@(posedge CLK) // R8
      stat_one_view[`SPW_B_GP1] == GROUP_INT_ONE)
    else $error("group one not mirrored");

  AST_GROUP2_MIRROR: assert property (@(posedge CLK) // R8
      stat_one_view[`SPW_B_GP2] == GROUP_INT_TWO)
    else $error("group two not mirrored");

  AST_STAT1_UNLATCHED: assert property (@(posedge CLK) // R8
      stat_one_q[`SPW_B_GP2:`SPW_B_GP1] == 2'b00)
    else $error("group bits latched");

  AST_SMI_FLOAT: assert property (@(posedge CLK) disable iff (!RESET_N) // R15
      CE && !smi_route_q[`SPW_B_ROUTE] |=> SYS_MGMT_INT_N_OE)
    else $error("smi driven");

  AST_SMI_DRIVE: assert property (@(posedge CLK) disable iff (!RESET_N) // R15
      CE && smi_route_q[`SPW_B_ROUTE] && group_smi |=> !SYS_MGMT_INT_N_OE)
    else $error("smi not driven");

  AST_SMI_GATE: assert property (@(posedge CLK) disable iff (!RESET_N) // R13
      CE && group_smi |=> !SYS_MGMT_INT_N_O)
    else $error("smi source missed");

  AST_SMI_IDLE: assert property (@(posedge CLK) disable iff (!RESET_N) // R13
      CE && !group_smi |=> SYS_MGMT_INT_N_O)
    else $error("smi without source");

  AST_WAKE_ON: assert property (@(posedge CLK) disable iff (!RESET_N) // R14
      CE && wake_any |=> !POWER_ON_OUT_N)
    else $error("no power on");

  AST_WAKE_OFF: assert property (@(posedge CLK) disable iff (!RESET_N) // R14
      CE && !wake_any |=> POWER_ON_OUT_N)
    else $error("power on without wake");

  AST_PG_SEL: assert property (@(posedge CLK) disable iff (!RESET_N) // R3
      CE |=> POWER_GOOD_SEL == $past(wake_enable_two_q[`SPW_B_PG]))
    else $error("pg");

  AST_OFF_PULSE: assert property (@(posedge CLK) disable iff (!RESET_N) // R4
      CE && POWER_BUTTON && !button_q && wake_enable_two_q[`SPW_B_OFF] |=> POWER_OFF_REQ)
    else $error("button power off missed");

  AST_OFF_GATED: assert property (@(posedge CLK) disable iff (!RESET_N) // R4
      CE && !wake_enable_two_q[`SPW_B_OFF] |=> !POWER_OFF_REQ)
    else $error("power off while disabled");

  AST_RSVD_ZERO: assert property (@(posedge CLK) // R16
      (wake_enable_two_q & ~`SPW_EN2_MASK) == `SPW_ZERO8)
    else $error("reserved set");

  AST_STAT2_RSVD: assert property (@(posedge CLK) // R16
      (stat_two_q & ~`SPW_STAT2_MASK) == `SPW_ZERO8)
    else $error("status two reserved set");

  AST_UNMAPPED: assert property (@(posedge CLK) disable iff (!RESET_N) // R16
      CE && setup && !mapped |=> PSLVERR)
    else $error("unmapped not refused");

  AST_ZERO_WAIT: assert property (@(posedge CLK) disable iff (!RESET_N)
      CE && setup |=> PREADY)
    else $error("ready missing");

  COV_WAKE: cover property (@(posedge CLK) disable iff (!RESET_N) $fell(POWER_ON_OUT_N));
  COV_SMI: cover property (@(posedge CLK) disable iff (!RESET_N) !SYS_MGMT_INT_N_OE);
  COV_OFF: cover property (@(posedge CLK) disable iff (!RESET_N) POWER_OFF_REQ);
  COV_ALARM: cover property (@(posedge CLK) disable iff (!RESET_N) stat_one_q[`SPW_B_ALARM]);
  COV_BUTTON: cover property (@(posedge CLK) disable iff (!RESET_N) stat_two_q[`SPW_B_BUTTON]);

endmodule // spwake_top
`default_nettype wire
